// ===== hdl/mprb_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - closed-loop current reads as 0..2047, 2047 meaning full run current.
// - ramp-up and ramp-down rates take 1..100000, default 2000 and 4000.
// - a commutation phase factor 0..200 is held for high-speed tuning.
// - cross-field index and value registers, reset to zero, set up routing.
// - eight flex setup registers each give two bits of the sixteen-bit flex register.
// - two LED setup registers drive LEDs three and two, and LED one green and red.
// - auto correction uses the commanded velocity unless the override is nonzero.
// - motor revolutions since power-on are counted read-only from zero.
// - cyclic link setup is read-only: period in us low half, sync offset high half.
// - a read-only counter from zero counts internal link CRC errors.
// - crawl velocity is homing velocity over 64 while the crawl register is zero.
// - homing times out after 60000 ms if the timeout register is zero, else its value.
// - temperature limits are read-only: warning low half, error high half.
// - overspeed percent 0..100 sits in bits 7:0, follow-error limit in bits 31:8.
// - bus voltage is sampled every 100 us; undervoltage needs N low readings in a row.
// - theoretical and encoder velocities read in 0.01 RPM units.
module mprb_regs #(
    parameter int MS_CYCLES = mprb_pkg::MS_PERIOD_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // motor core status
    input  wire logic [10:0] current_level,
    input  wire logic [31:0] computed_velocity,
    input  wire logic [31:0] encoder_velocity,
    input  wire logic        revolution_done,
    input  wire logic [31:0] cyclic_link_setup,
    input  wire logic        link_crc_error,
    input  wire logic [15:0] temp_warn_limit,
    input  wire logic [15:0] temp_error_limit,
    input  wire logic [31:0] commanded_velocity,
    input  wire logic [31:0] homing_velocity,
    input  wire logic        homing_start,
    input  wire logic        homing_found,
    input  wire logic        bus_voltage_low,
    input  wire logic        undervoltage_clear,
    // configuration and status outputs
    output var  logic [7:0]  commutation_phase_factor,
    output var  logic [16:0] current_ramp_up_rate,
    output var  logic [16:0] current_ramp_down_rate,
    output var  logic [31:0] crossfield_index,
    output var  logic [31:0] crossfield_value,
    output var  logic        crossfield_write,
    output var  logic [15:0] flex_bit_select,
    output var  logic [31:0] led_pair_a_setup,
    output var  logic [31:0] led_pair_b_setup,
    output var  logic [31:0] autocorrect_velocity_eff,
    output var  logic [31:0] homing_crawl_velocity_eff,
    output var  logic        homing_timeout_flag,
    output var  logic [7:0]  overspeed_percent,
    output var  logic [23:0] overspeed_follow_limit,
    output var  logic        undervoltage_error
);
    // ****************************************
    // bus decode
    // ****************************************
    logic [31:0] ro_rev_q, ro_crc_q, ro_cyc_q, ro_temp_q;
    logic [31:0] phase_q, ramp_up_q, ramp_down_q, xf_idx_q, xf_val_q;
    logic [31:0] flex_q [mprb_pkg::FLEX_COUNT];
    logic [31:0] led_a_q, led_b_q, autocorr_q, crawl_q, tmo_q, catchup_q, uv_cnt_q;
    logic [31:0] rdata_d;
    logic        wr_en;
    logic [7:0]  idx;

    assign idx   = paddr[9:2];
    assign wr_en = psel && penable && pwrite;

    // clamp a value into [lo, hi]
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // true when a write hits register index i
    function automatic logic hit(input logic [7:0] i, input logic [7:0] a, input logic w);
        return w && (a == i);
    endfunction

    // ****************************************
    // writable registers
    // ****************************************
    // out-of-range values are clamped, so the loops never see an illegal setting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_q     <= mprb_pkg::RST_ZERO;
            ramp_up_q   <= mprb_pkg::RST_RAMP_UP;
            ramp_down_q <= mprb_pkg::RST_RAMP_DOWN;
            xf_idx_q    <= mprb_pkg::RST_ZERO;
            xf_val_q    <= mprb_pkg::RST_ZERO;
            led_a_q     <= mprb_pkg::RST_ZERO;
            led_b_q     <= mprb_pkg::RST_ZERO;
            autocorr_q  <= mprb_pkg::RST_ZERO;
            crawl_q     <= mprb_pkg::RST_ZERO;
            tmo_q       <= mprb_pkg::RST_ZERO;
            catchup_q   <= mprb_pkg::RST_ZERO;
            uv_cnt_q    <= mprb_pkg::RST_UV_DEBOUNCE;
        end else begin
            if (hit(mprb_pkg::IDX_PHASE_FACTOR, idx, wr_en)) begin
                phase_q <= clamp(pwdata, mprb_pkg::RST_ZERO, mprb_pkg::PHASE_MAX);
            end
            if (hit(mprb_pkg::IDX_RAMP_UP, idx, wr_en)) begin
                ramp_up_q <= clamp(pwdata, mprb_pkg::RAMP_MIN, mprb_pkg::RAMP_MAX);
            end
            if (hit(mprb_pkg::IDX_RAMP_DOWN, idx, wr_en)) begin
                ramp_down_q <= clamp(pwdata, mprb_pkg::RAMP_MIN, mprb_pkg::RAMP_MAX);
            end
            if (hit(mprb_pkg::IDX_XF_INDEX, idx, wr_en)) xf_idx_q <= pwdata;
            if (hit(mprb_pkg::IDX_XF_VALUE, idx, wr_en)) xf_val_q <= pwdata;
            if (hit(mprb_pkg::IDX_LED_A, idx, wr_en)) led_a_q <= pwdata;
            if (hit(mprb_pkg::IDX_LED_B, idx, wr_en)) led_b_q <= pwdata;
            if (hit(mprb_pkg::IDX_AUTOCORR_VEL, idx, wr_en)) autocorr_q <= pwdata;
            if (hit(mprb_pkg::IDX_CRAWL_VEL, idx, wr_en)) crawl_q <= pwdata;
            if (hit(mprb_pkg::IDX_HOME_TIMEOUT, idx, wr_en)) tmo_q <= pwdata;
            if (hit(mprb_pkg::IDX_CATCHUP, idx, wr_en)) begin
                // percent field limited to 100
                catchup_q <= {pwdata[31:8], (pwdata[7:0] > mprb_pkg::OVERSPEED_MAX) ?
                              mprb_pkg::OVERSPEED_MAX : pwdata[7:0]};
            end
            if (hit(mprb_pkg::IDX_UV_DEBOUNCE, idx, wr_en)) uv_cnt_q <= pwdata;
        end
    end

    // flex setup bank, two flex bits per word
    genvar g;
    generate
        for (g = 0; g < mprb_pkg::FLEX_COUNT; g++) begin : g_flex
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    flex_q[g] <= mprb_pkg::RST_ZERO;
                end else if (hit(8'(mprb_pkg::IDX_FLEX_FIRST + 8'(g)), idx, wr_en)) begin
                    flex_q[g] <= pwdata;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    flex_bit_select[2*g +: 2] <= 2'b00;
                end else begin
                    flex_bit_select[2*g +: 2] <= flex_q[g][1:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // read-only status registers
    // ****************************************
    // revolution and crc counts wrap rather than saturate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ro_rev_q <= mprb_pkg::RST_ZERO;
            ro_crc_q <= mprb_pkg::RST_ZERO;
        end else begin
            if (revolution_done) begin
                ro_rev_q <= ro_rev_q + 32'h0000_0001;
            end
            if (link_crc_error) begin
                ro_crc_q <= ro_crc_q + 32'h0000_0001;
            end
        end
    end

    // link and thermal snapshots, bus cannot write them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ro_cyc_q  <= mprb_pkg::RST_ZERO;
            ro_temp_q <= mprb_pkg::RST_ZERO;
        end else begin
            ro_cyc_q  <= cyclic_link_setup;
            ro_temp_q <= {temp_error_limit, temp_warn_limit};
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (idx >= mprb_pkg::IDX_FLEX_FIRST && idx < mprb_pkg::IDX_LED_A) begin
            rdata_d = flex_q[idx[2:0]];
        end else begin
            case (idx)
                mprb_pkg::IDX_PHASE_FACTOR:  rdata_d = phase_q;
                mprb_pkg::IDX_CURRENT_LEVEL: rdata_d = {21'h00_0000, current_level};
                mprb_pkg::IDX_RAMP_UP:       rdata_d = ramp_up_q;
                mprb_pkg::IDX_RAMP_DOWN:     rdata_d = ramp_down_q;
                mprb_pkg::IDX_XF_INDEX:      rdata_d = xf_idx_q;
                mprb_pkg::IDX_XF_VALUE:      rdata_d = xf_val_q;
                mprb_pkg::IDX_LED_A:         rdata_d = led_a_q;
                mprb_pkg::IDX_LED_B:         rdata_d = led_b_q;
                mprb_pkg::IDX_AUTOCORR_VEL:  rdata_d = autocorr_q;
                mprb_pkg::IDX_COMPUTED_VEL:  rdata_d = computed_velocity;
                mprb_pkg::IDX_REV_COUNT:     rdata_d = ro_rev_q;
                mprb_pkg::IDX_CYCLIC_SETUP:  rdata_d = ro_cyc_q;
                mprb_pkg::IDX_CRC_ERRORS:    rdata_d = ro_crc_q;
                mprb_pkg::IDX_CRAWL_VEL:     rdata_d = crawl_q;
                mprb_pkg::IDX_HOME_TIMEOUT:  rdata_d = tmo_q;
                mprb_pkg::IDX_TEMP_LIMITS:   rdata_d = ro_temp_q;
                mprb_pkg::IDX_CATCHUP:       rdata_d = catchup_q;
                mprb_pkg::IDX_UV_DEBOUNCE:   rdata_d = uv_cnt_q;
                mprb_pkg::IDX_ENCODER_VEL:   rdata_d = encoder_velocity;
                default:                     rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // read data latched in setup; ready in first access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0; // unmapped reads return zero, writes dropped
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // ****************************************
    // effective setpoints for the motion core
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            commutation_phase_factor  <= 8'h00;
            current_ramp_up_rate      <= 17'(mprb_pkg::RST_RAMP_UP);
            current_ramp_down_rate    <= 17'(mprb_pkg::RST_RAMP_DOWN);
            crossfield_index          <= 32'h0000_0000;
            crossfield_value          <= 32'h0000_0000;
            crossfield_write          <= 1'b0;
            led_pair_a_setup          <= 32'h0000_0000;
            led_pair_b_setup          <= 32'h0000_0000;
            autocorrect_velocity_eff  <= 32'h0000_0000;
            homing_crawl_velocity_eff <= 32'h0000_0000;
            overspeed_percent         <= 8'h00;
            overspeed_follow_limit    <= 24'h00_0000;
        end else begin
            commutation_phase_factor  <= phase_q[7:0];
            current_ramp_up_rate      <= ramp_up_q[16:0];
            current_ramp_down_rate    <= ramp_down_q[16:0];
            crossfield_index          <= xf_idx_q;
            crossfield_value          <= xf_val_q;
            // pulse so the switch board latches the entry
            crossfield_write          <= hit(mprb_pkg::IDX_XF_VALUE, idx, wr_en);
            led_pair_a_setup          <= led_a_q;
            led_pair_b_setup          <= led_b_q;
            autocorrect_velocity_eff  <= (autocorr_q != 32'h0000_0000) ? autocorr_q : commanded_velocity;
            homing_crawl_velocity_eff <= (crawl_q != 32'h0000_0000) ? crawl_q
                : 32'($signed(homing_velocity) >>> mprb_pkg::CRAWL_SHIFT);
            overspeed_percent         <= catchup_q[7:0];
            overspeed_follow_limit    <= catchup_q[31:8];
        end
    end

    // ****************************************
    // homing timeout
    // ****************************************
    logic                          ms_tick, uv_tick;
    logic [31:0]                   ms_cnt_q, uv_run_q;
    mprb_pkg::mprb_home_state_type hs_q;

    mprb_tick #(.PERIOD(MS_CYCLES)) u_ms_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (ms_tick)
    );

    // millisecond resolution; first tick may land early by up to one ms
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hs_q                <= mprb_pkg::HS_IDLE;
            ms_cnt_q            <= 32'h0000_0000;
            homing_timeout_flag <= 1'b0;
        end else begin
            case (hs_q)
                mprb_pkg::HS_IDLE, mprb_pkg::HS_DONE: begin
                    if (homing_start) begin
                        hs_q                <= mprb_pkg::HS_SEARCH;
                        ms_cnt_q            <= 32'h0000_0000;
                        homing_timeout_flag <= 1'b0;
                    end
                end
                mprb_pkg::HS_SEARCH: begin
                    if (homing_found) begin
                        hs_q <= mprb_pkg::HS_IDLE;
                    end else if (ms_cnt_q >= ((tmo_q == 32'h0000_0000) ? mprb_pkg::HOME_TIMEOUT_DFLT : tmo_q)) begin
                        hs_q                <= mprb_pkg::HS_DONE;
                        homing_timeout_flag <= 1'b1;
                    end else if (ms_tick) begin
                        ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
                    end
                end
                default: hs_q <= mprb_pkg::HS_IDLE;
            endcase
        end
    end

    // ****************************************
    // undervoltage debounce
    // ****************************************
    mprb_tick #(.PERIOD(mprb_pkg::UV_PERIOD_CYC)) u_uv_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (uv_tick)
    );

    // a low sample that completes the run of uv_cnt_q readings wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uv_run_q           <= 32'h0000_0000;
            undervoltage_error <= 1'b0;
        end else begin
            if (uv_tick) begin
                if (bus_voltage_low) begin
                    if (uv_run_q != 32'hffff_ffff) begin
                        uv_run_q <= uv_run_q + 32'h0000_0001;
                    end
                end else begin
                    uv_run_q <= 32'h0000_0000;
                end
            end
            if (uv_tick && bus_voltage_low && (uv_run_q + 32'h0000_0001 >= uv_cnt_q)) begin
                undervoltage_error <= 1'b1;
            end else if (undervoltage_clear) begin
                undervoltage_error <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/mprb_pkg.sv
package mprb_pkg;
    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] IDX_PHASE_FACTOR   = 8'hd8;
    localparam logic [7:0] IDX_CURRENT_LEVEL  = 8'hd9;
    localparam logic [7:0] IDX_RAMP_UP        = 8'hda;
    localparam logic [7:0] IDX_RAMP_DOWN      = 8'hdb;
    localparam logic [7:0] IDX_XF_INDEX       = 8'hde;
    localparam logic [7:0] IDX_XF_VALUE       = 8'hdf;
    localparam logic [7:0] IDX_FLEX_FIRST     = 8'he0;
    localparam logic [7:0] IDX_LED_A          = 8'he8;
    localparam logic [7:0] IDX_LED_B          = 8'he9;
    localparam logic [7:0] IDX_AUTOCORR_VEL   = 8'hec;
    localparam logic [7:0] IDX_COMPUTED_VEL   = 8'hed;
    localparam logic [7:0] IDX_REV_COUNT      = 8'hee;
    localparam logic [7:0] IDX_CYCLIC_SETUP   = 8'hef;
    localparam logic [7:0] IDX_CRC_ERRORS     = 8'hf1;
    localparam logic [7:0] IDX_CRAWL_VEL      = 8'hf2;
    localparam logic [7:0] IDX_HOME_TIMEOUT   = 8'hf3;
    localparam logic [7:0] IDX_TEMP_LIMITS    = 8'hf4;
    localparam logic [7:0] IDX_CATCHUP        = 8'hf5;
    localparam logic [7:0] IDX_UV_DEBOUNCE    = 8'hfc;
    localparam logic [7:0] IDX_ENCODER_VEL    = 8'hfd;
    localparam int         FLEX_COUNT         = 8;

    // ****************************************
    // reset values, limits and timing
    // ****************************************
    localparam logic [31:0] RST_RAMP_UP        = 32'h0000_07d0;
    localparam logic [31:0] RST_RAMP_DOWN      = 32'h0000_0fa0;
    localparam logic [31:0] RST_UV_DEBOUNCE    = 32'h0000_000a;
    localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
    localparam logic [31:0] RAMP_MIN           = 32'h0000_0001;
    localparam logic [31:0] RAMP_MAX           = 32'h0001_86a0;
    localparam logic [31:0] PHASE_MAX          = 32'h0000_00c8;
    localparam logic [10:0] CURRENT_FULL       = 11'h7ff;
    localparam logic [7:0]  OVERSPEED_MAX      = 8'h64;
    localparam logic [31:0] HOME_TIMEOUT_DFLT  = 32'h0000_ea60;
    localparam int          CRAWL_SHIFT        = 6;
    localparam int          CLK_HZ             = 20000000;
    localparam int          UV_PERIOD_US       = 100;
    localparam int          UV_PERIOD_CYC      = (CLK_HZ / 1000000) * UV_PERIOD_US;
    localparam int          MS_PERIOD_CYC      = CLK_HZ / 1000;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b001,
        HS_SEARCH = 3'b010,
        HS_DONE   = 3'b100
    } mprb_home_state_type;
endpackage

// ===== hdl/mprb_tick.sv
`timescale 1ns/10ps
`default_nettype none
// free-running one-cycle enable every PERIOD cycles
module mprb_tick #(
    parameter int PERIOD = 2000
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output var  logic tick
);
    logic [31:0] cnt_q;

    // ****************************************
    // divider
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verification/mprb_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port checks for the register bank
// ****************************************
module mprb_sva (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [10:0] current_level,
    input  wire logic [7:0]  commutation_phase_factor,
    input  wire logic [16:0] current_ramp_up_rate,
    input  wire logic        crossfield_write,
    input  wire logic [7:0]  overspeed_percent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // zero wait states, so a late pready means a stuck access phase
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no pready");
    a_ready_one: assert property (pready |=> !pready)
        else $error("pready too long");
    a_no_slverr: assert property (!pslverr)
        else $error("pslverr raised");
    a_current_read: assert property (psel && !penable && !pwrite && paddr == 12'h0364
        |=> prdata == {21'h00_0000, $past(current_level)}) else $error("current read wrong");
    a_xf_strobe: assert property (psel && penable && pwrite && paddr == 12'h037c
        |=> crossfield_write) else $error("no xf strobe");
    // clamped fields stay in range
    a_ramp_range: assert property (current_ramp_up_rate inside {[17'h0_0001:17'h1_86a0]})
        else $error("ramp range");
    a_phase_max: assert property (commutation_phase_factor <= 8'hc8)
        else $error("phase range");
    a_ospd_max: assert property (overspeed_percent <= 8'h64)
        else $error("overspeed range");
endmodule
bind mprb_regs mprb_sva u_sva (.*);
`default_nettype wire

// ===== verification/mprb_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host side apb master
// ****************************************
module mprb_host (
    input  wire logic        clk_sys,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata
);
    // bus idle at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one transfer; an edge passes first so a release never meets a new request
    task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                        output logic [31:0] r, output int n);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/motor_param_register_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module motor_param_register_bank_tb;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, crossfield_write;
    logic        revolution_done, link_crc_error, homing_start, homing_found;
    logic        bus_voltage_low, undervoltage_clear, homing_timeout_flag, undervoltage_error;
    logic [7:0]  commutation_phase_factor, overspeed_percent;
    logic [10:0] current_level;
    logic [11:0] paddr;
    logic [15:0] temp_warn_limit, temp_error_limit, flex_bit_select;
    logic [16:0] current_ramp_up_rate, current_ramp_down_rate;
    logic [23:0] overspeed_follow_limit;
    logic [31:0] pwdata, prdata, computed_velocity, encoder_velocity, cyclic_link_setup;
    logic [31:0] commanded_velocity, homing_velocity, crossfield_index, crossfield_value;
    logic [31:0] led_pair_a_setup, led_pair_b_setup, autocorrect_velocity_eff, homing_crawl_velocity_eff;
    int          failures, cmp_count, n;

    // short ms divider keeps homing brief
    mprb_regs #(.MS_CYCLES(20)) dut (.*);
    mprb_host host (.*);

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic results;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // a used-up wait ends the run at once
    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            $display("MISMATCH t=%0t wait ran out", $time);
            results();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        int          k;
        host.xfer(1'b1, i, d, r, k);
        bound(k, 20);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] r;
        int          k;
        host.xfer(1'b0, i, 32'h0000_0000, r, k);
        bound(k, 20);
        check(r, e);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(mprb_pkg::IDX_RAMP_UP, 32'h0000_07d0);
        rd(mprb_pkg::IDX_RAMP_DOWN, 32'h0000_0fa0);
        rd(mprb_pkg::IDX_UV_DEBOUNCE, 32'h0000_000a);
        rd(mprb_pkg::IDX_XF_INDEX, 32'h0000_0000);
        rd(8'h00, 32'h0000_0000);
        check(32'(current_ramp_down_rate), 32'h0000_0fa0);
        $display("reset test done");
    endtask
    task automatic t_write;
        wr(mprb_pkg::IDX_PHASE_FACTOR, 32'h0000_00c9);
        rd(mprb_pkg::IDX_PHASE_FACTOR, 32'h0000_00c8);
        wr(mprb_pkg::IDX_RAMP_UP, 32'h0000_0001);
        rd(mprb_pkg::IDX_RAMP_UP, 32'h0000_0001);
        wr(mprb_pkg::IDX_XF_VALUE, 32'h1234_5678);
        wr(mprb_pkg::IDX_LED_B, 32'h0000_0005);
        wr(mprb_pkg::IDX_CATCHUP, 32'h0001_2378);
        for (int g = 0; g < 8; g++) wr(mprb_pkg::IDX_FLEX_FIRST + 8'(g), 32'(g % 4));
        cyc(3);
        check(crossfield_value, 32'h1234_5678);
        check(led_pair_b_setup, 32'h0000_0005);
        check(32'(flex_bit_select), 32'h0000_e4e4);
        check(32'(overspeed_percent), 32'h0000_0064);
        check(32'(overspeed_follow_limit), 32'h0000_0123);
        check(32'(commutation_phase_factor), 32'h0000_00c8);
        check(32'(current_ramp_up_rate), 32'h0000_0001);
        $display("write test done");
    endtask
    task automatic t_readonly;
        current_level <= 11'h7ff;
        cyclic_link_setup <= 32'h0032_03e8;
        {temp_error_limit, temp_warn_limit} <= 32'h0064_0050;
        computed_velocity <= 32'hfffb_6c20;
        encoder_velocity <= 32'h0004_93e0;
        repeat (3) begin
            {revolution_done, link_crc_error} <= 2'b11;
            cyc(1);
            {revolution_done, link_crc_error} <= 2'b00;
            cyc(1);
        end
        wr(mprb_pkg::IDX_REV_COUNT, 32'hffff_ffff);
        rd(mprb_pkg::IDX_REV_COUNT, 32'h0000_0003);
        rd(mprb_pkg::IDX_CRC_ERRORS, 32'h0000_0003);
        rd(mprb_pkg::IDX_CURRENT_LEVEL, 32'h0000_07ff);
        rd(mprb_pkg::IDX_CYCLIC_SETUP, 32'h0032_03e8);
        rd(mprb_pkg::IDX_TEMP_LIMITS, 32'h0064_0050);
        rd(mprb_pkg::IDX_COMPUTED_VEL, 32'hfffb_6c20);
        rd(mprb_pkg::IDX_ENCODER_VEL, 32'h0004_93e0);
        $display("read-only test done");
    endtask
    task automatic t_motion;
        commanded_velocity <= 32'hffff_8ad0;
        homing_velocity <= 32'h0000_0280;
        cyc(3);
        check(autocorrect_velocity_eff, 32'hffff_8ad0);
        check(homing_crawl_velocity_eff, 32'h0000_000a);
        wr(mprb_pkg::IDX_AUTOCORR_VEL, 32'h0000_0064);
        wr(mprb_pkg::IDX_CRAWL_VEL, 32'h0000_0005);
        wr(mprb_pkg::IDX_HOME_TIMEOUT, 32'h0000_0003);
        cyc(3);
        check(autocorrect_velocity_eff, 32'h0000_0064);
        check(homing_crawl_velocity_eff, 32'h0000_0005);
        homing_start <= 1'b1;
        cyc(1);
        homing_start <= 1'b0;
        cyc(34);
        check(32'(homing_timeout_flag), 32'h0000_0000);
        for (n = 0; n < 60 && homing_timeout_flag !== 1'b1; n++) cyc(1);
        bound(n, 60);
        $display("motion test done");
    endtask
    task automatic t_undervolt;
        wr(mprb_pkg::IDX_UV_DEBOUNCE, 32'h0000_0002);
        bus_voltage_low <= 1'b1;
        cyc(1900);
        check(32'(undervoltage_error), 32'h0000_0000);
        for (n = 0; n < 2400 && undervoltage_error !== 1'b1; n++) cyc(1);
        bound(n, 2400);
        bus_voltage_low <= 1'b0;
        undervoltage_clear <= 1'b1;
        cyc(2);
        undervoltage_clear <= 1'b0;
        cyc(2);
        check(32'(undervoltage_error), 32'h0000_0000);
        $display("undervoltage test done");
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {revolution_done, link_crc_error, homing_start, homing_found, bus_voltage_low, undervoltage_clear} = '0;
        {current_level, computed_velocity, encoder_velocity, cyclic_link_setup} = '0;
        {temp_warn_limit, temp_error_limit, commanded_velocity, homing_velocity} = '0;
        failures = 0;
        cmp_count = 0;
        cyc(2);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_readonly();
        t_motion();
        t_undervolt();
        results();
    end
endmodule
`default_nettype wire
